// *** hw/ifs_bus_detect.sv ***
// start and stop condition detector with bus-occupied flag
// assumes scl and sda arrive asynchronously from the bus pins
`default_nettype none
module ifs_bus_detect (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// detector soft reset pulse
	input  wire logic soft_reset_i,
	// bus lines
	input  wire logic scl_i,
	input  wire logic sda_i,
	// results
	output logic      occupied_o,
	output logic      start_o,
	output logic      stop_o
);
	logic scl_meta;
	logic scl_sync;
	logic scl_prev;
	logic sda_meta;
	logic sda_sync;
	logic sda_prev;
	logic next_scl_prev;
	logic next_sda_prev;
	logic next_occupied;
	logic next_start;
	logic next_stop;
	logic start_seen;
	logic stop_seen;

	assign start_seen = scl_sync && scl_prev && sda_prev && !sda_sync;
	assign stop_seen = scl_sync && scl_prev && !sda_prev && sda_sync;

	always_comb begin
		next_scl_prev = scl_sync;
		next_sda_prev = sda_sync;
		next_start = start_seen;
		next_stop = stop_seen;
		next_occupied = occupied_o;
		if (start_seen) begin
			next_occupied = 1'b1;
		end else if (stop_seen) begin
			next_occupied = 1'b0;
		end
		// edge history reloads from the lines, so a low sda cannot fake a start
		if (soft_reset_i) begin
			next_start = 1'b0;
			next_stop = 1'b0;
			next_occupied = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scl_meta <= ifs_pkg::IFS_LINE_IDLE;
			scl_sync <= ifs_pkg::IFS_LINE_IDLE;
			scl_prev <= ifs_pkg::IFS_LINE_IDLE;
			sda_meta <= ifs_pkg::IFS_LINE_IDLE;
			sda_sync <= ifs_pkg::IFS_LINE_IDLE;
			sda_prev <= ifs_pkg::IFS_LINE_IDLE;
			occupied_o <= 1'b0;
			start_o <= 1'b0;
			stop_o <= 1'b0;
		end else begin
			scl_meta <= scl_i;
			scl_sync <= scl_meta;
			scl_prev <= next_scl_prev;
			sda_meta <= sda_i;
			sda_sync <= sda_meta;
			sda_prev <= next_sda_prev;
			occupied_o <= next_occupied;
			start_o <= next_start;
			stop_o <= next_stop;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_SOFT_RESET_QUIET: assert property (soft_reset_i |=> !occupied_o && !start_o && !stop_o)
		else $error("detector not idle after soft reset");
endmodule // ifs_bus_detect
`default_nettype wire

// *** hw/ifs_fifo2.sv ***
// two-entry shift buffer with valid/ready on both sides and a drain input
// assumes a single clock and a synchronous active-high reset
`default_nettype none
module ifs_fifo2 #(
	parameter int WIDTH = ifs_pkg::IFS_BYTE_W,
	parameter int DEPTH = ifs_pkg::IFS_FIFO_DEPTH
) (
	// clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	// drain pulse
	input  wire logic                       flush_i,
	// filling side
	input  wire logic                       in_valid_i,
	input  wire logic [WIDTH-1:0]           in_data_i,
	output logic                            in_ready_o,
	// draining side
	output logic                            out_valid_o,
	output logic [WIDTH-1:0]                out_data_o,
	input  wire logic                       out_ready_i,
	// occupancy, also the write index of the next byte, one lower when a pop shifts in the same cycle
	output logic [$clog2(DEPTH+1)-1:0]      count_o
);
	localparam int CW = $clog2(DEPTH+1);

	logic [DEPTH-1:0][WIDTH-1:0] mem;
	logic [DEPTH-1:0][WIDTH-1:0] next_mem;
	logic [CW-1:0]               next_count;
	logic                        next_in_ready;
	logic                        next_out_valid;
	logic                        push;
	logic                        pop;
	logic [CW-1:0]               wr_idx;

	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem[0];

	// head always sits in entry 0, so read data come straight from a flop
	always_comb begin
		next_mem = mem;
		next_count = count_o;
		wr_idx = count_o - CW'(pop);
		if (flush_i) begin
			next_count = '0;
		end else begin
			if (pop) begin
				for (int i = 0; i < DEPTH - 1; i++) begin
					next_mem[i] = mem[i+1];
				end
			end
			if (push) begin
				next_mem[wr_idx] = in_data_i;
			end
			next_count = count_o + CW'(push) - CW'(pop);
		end
		// ready is registered: a full buffer refuses in the cycle of a pop and accepts from the next cycle
		next_in_ready = (next_count != CW'(DEPTH));
		next_out_valid = (next_count != '0);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mem <= '0;
			count_o <= '0;
			in_ready_o <= 1'b1;
			out_valid_o <= 1'b0;
		end else begin
			mem <= next_mem;
			count_o <= next_count;
			in_ready_o <= next_in_ready;
			out_valid_o <= next_out_valid;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_COUNT_IN_RANGE: assert property (count_o <= CW'(DEPTH))
		else $error("occupancy above buffer depth");
	AST_DRAIN_RESTART: assert property (flush_i |=> (count_o == '0) && !out_valid_o)
		else $error("write index did not restart after drain");
endmodule // ifs_fifo2
`default_nettype wire

// *** hw/ifs_top.sv ***
// fifo occupancy, transmit drain and detector reset registers of the i2c block
// assumes classic wishbone on clk_i; protocol engines sit on the stream ports
`default_nettype none
module ifs_top (
	// clock and reset
	input  wire logic                                                clk_i,
	input  wire logic                                                rst_i,
	// wishbone slave
	input  wire logic [31:0]                                         adr_i,
	input  wire logic [31:0]                                         dat_i,
	input  wire logic [3:0]                                          sel_i,
	input  wire logic                                                we_i,
	input  wire logic                                                cyc_i,
	input  wire logic                                                stb_i,
	output logic [31:0]                                              dat_o,
	output logic                                                     ack_o,
	// bus lines
	input  wire logic                                                scl_i,
	input  wire logic                                                sda_i,
	// detector results
	output logic                                                     bus_occupied_flag_o,
	output logic                                                     start_detect_o,
	output logic                                                     stop_detect_o,
	// fifo filling side, index per package fifo order
	input  wire ifs_pkg::ifs_stream_type [ifs_pkg::IFS_FIFO_COUNT-1:0] push_i,
	output logic [ifs_pkg::IFS_FIFO_COUNT-1:0]                       push_ready_o,
	// fifo draining side
	output ifs_pkg::ifs_stream_type [ifs_pkg::IFS_FIFO_COUNT-1:0]    pop_o,
	input  wire logic [ifs_pkg::IFS_FIFO_COUNT-1:0]                  pop_ready_i,
	// stretch control and timeout events
	output logic [3:0]                                               master_stretch_mode_o,
	output logic [3:0]                                               slave_stretch_mode_o,
	input  wire logic                                                master_stretch_timeout_i,
	input  wire logic                                                slave_stretch_timeout_i
);
	localparam int NF = ifs_pkg::IFS_FIFO_COUNT;
	localparam int MTX = ifs_pkg::IFS_FIFO_MTX;
	localparam int STX = ifs_pkg::IFS_FIFO_STX;
	localparam int SRX = ifs_pkg::IFS_FIFO_SRX;
	localparam int MRX = ifs_pkg::IFS_FIFO_MRX;

	// bus request decode
	logic             hit_fsta;
	logic             hit_shcon;
	logic             hit_asscl;
	logic             wr_take;
	logic             rd_capture;
	logic             next_ack;
	logic [31:0]      next_dat;
	logic [15:0]      rd_word;

	// fifo state
	logic [NF-1:0][1:0] occ;
	logic [NF-1:0]      drain;
	logic [NF-1:0]      out_valid;
	logic [NF-1:0][7:0] out_data;

	// detector soft reset pulse, no storage behind it
	logic             det_reset;

	// stretch control register
	logic [3:0]       next_mst_mode;
	logic [3:0]       next_slv_mode;
	logic             mst_timeout;
	logic             slv_timeout;
	logic             next_mst_timeout;
	logic             next_slv_timeout;

	// word address compare; the two low address bits never select a register
	always_comb begin
		hit_fsta = 1'b0;
		hit_shcon = 1'b0;
		hit_asscl = 1'b0;
		if (adr_i[31:2] == ifs_pkg::IFS_ADDR_FIFO_STATUS[31:2]) begin
			hit_fsta = 1'b1;
		end else if (adr_i[31:2] == ifs_pkg::IFS_ADDR_SHARED_CTRL[31:2]) begin
			hit_shcon = 1'b1;
		end else if (adr_i[31:2] == ifs_pkg::IFS_ADDR_STRETCH_CTRL[31:2]) begin
			hit_asscl = 1'b1;
		end
	end

	// writes land at the edge where ack is seen; reads are captured one edge earlier
	assign wr_take = cyc_i && stb_i && we_i && ack_o;
	assign rd_capture = cyc_i && stb_i && !we_i && !ack_o;

	// drain bits act only on a written one and leave nothing stored
	always_comb begin
		drain = '0;
		if (wr_take && hit_fsta && sel_i[1]) begin
			drain[MTX] = dat_i[ifs_pkg::IFS_BIT_MTX_DRAIN];
			drain[STX] = dat_i[ifs_pkg::IFS_BIT_STX_DRAIN];
		end
	end

	assign det_reset = wr_take && hit_shcon && sel_i[0] && dat_i[ifs_pkg::IFS_BIT_DET_RESET];

	// read word assembly; write-only and reserved bits read zero
	always_comb begin
		rd_word = 16'h0000;
		if (hit_fsta) begin
			rd_word[ifs_pkg::IFS_BIT_MRX_OCC_LO +: 2] = occ[MRX];
			rd_word[ifs_pkg::IFS_BIT_MTX_OCC_LO +: 2] = occ[MTX];
			rd_word[ifs_pkg::IFS_BIT_SRX_OCC_LO +: 2] = occ[SRX];
			rd_word[ifs_pkg::IFS_BIT_STX_OCC_LO +: 2] = occ[STX];
		end else if (hit_asscl) begin
			rd_word[ifs_pkg::IFS_BIT_SLV_TIMEOUT] = slv_timeout;
			rd_word[ifs_pkg::IFS_BIT_MST_TIMEOUT] = mst_timeout;
			rd_word[ifs_pkg::IFS_BIT_SLV_STRETCH_LO +: 4] = slave_stretch_mode_o;
			rd_word[ifs_pkg::IFS_BIT_MST_STRETCH_LO +: 4] = master_stretch_mode_o;
		end
	end

	// one wait state on every access; unmapped addresses ack with zero data
	always_comb begin
		next_ack = cyc_i && stb_i && !ack_o;
		next_dat = dat_o;
		if (rd_capture) begin
			next_dat = {16'h0000, rd_word};
		end
	end

	// stretch control: modes are plain storage, timeouts clear on read
	always_comb begin
		next_mst_mode = master_stretch_mode_o;
		next_slv_mode = slave_stretch_mode_o;
		next_mst_timeout = mst_timeout;
		next_slv_timeout = slv_timeout;
		if (wr_take && hit_asscl && sel_i[0]) begin
			next_mst_mode = dat_i[ifs_pkg::IFS_BIT_MST_STRETCH_LO +: 4];
			next_slv_mode = dat_i[ifs_pkg::IFS_BIT_SLV_STRETCH_LO +: 4];
		end
		if (rd_capture && hit_asscl) begin
			next_mst_timeout = 1'b0;
			next_slv_timeout = 1'b0;
		end
		// a timeout in the clearing cycle survives the read
		if (master_stretch_timeout_i) begin
			next_mst_timeout = 1'b1;
		end
		if (slave_stretch_timeout_i) begin
			next_slv_timeout = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= ifs_pkg::IFS_RST_WB_DATA;
			master_stretch_mode_o <= ifs_pkg::IFS_RST_STRETCH_CTRL[3:0];
			slave_stretch_mode_o <= ifs_pkg::IFS_RST_STRETCH_CTRL[7:4];
			mst_timeout <= ifs_pkg::IFS_RST_STRETCH_CTRL[8];
			slv_timeout <= ifs_pkg::IFS_RST_STRETCH_CTRL[9];
		end else begin
			ack_o <= next_ack;
			dat_o <= next_dat;
			master_stretch_mode_o <= next_mst_mode;
			slave_stretch_mode_o <= next_slv_mode;
			mst_timeout <= next_mst_timeout;
			slv_timeout <= next_slv_timeout;
		end
	end

	// four identical two-byte buffers; receive buffers simply never see a drain
	for (genvar g = 0; g < NF; g++) begin : g_fifo
		ifs_fifo2 #(
			.WIDTH (ifs_pkg::IFS_BYTE_W),
			.DEPTH (ifs_pkg::IFS_FIFO_DEPTH)
		) u_fifo (
			.clk_i       (clk_i),
			.rst_i       (rst_i),
			.flush_i     (drain[g]),
			.in_valid_i  (push_i[g].valid),
			.in_data_i   (push_i[g].data),
			.in_ready_o  (push_ready_o[g]),
			.out_valid_o (out_valid[g]),
			.out_data_o  (out_data[g]),
			.out_ready_i (pop_ready_i[g]),
			.count_o     (occ[g])
		);
		assign pop_o[g].valid = out_valid[g];
		assign pop_o[g].data = out_data[g];
	end

	ifs_bus_detect u_detect (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.soft_reset_i (det_reset),
		.scl_i        (scl_i),
		.sda_i        (sda_i),
		.occupied_o   (bus_occupied_flag_o),
		.start_o      (start_detect_o),
		.stop_o       (stop_detect_o)
	);

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence seq_fsta_write;
		cyc_i && stb_i && we_i && ack_o && hit_fsta && sel_i[1];
	endsequence

	sequence seq_shcon_reset;
		cyc_i && stb_i && we_i && ack_o && hit_shcon && sel_i[0] && dat_i[0];
	endsequence

	sequence seq_fsta_read;
		cyc_i && stb_i && !we_i && !ack_o && hit_fsta;
	endsequence

	property p_drain_empties(int bitpos, logic [1:0] cnt_after);
		seq_fsta_write ##0 dat_i[bitpos] |=> cnt_after == ifs_pkg::IFS_OCC_EMPTY;
	endproperty

	AST_MTX_DRAIN: assert property (seq_fsta_write ##0 dat_i[9] |=> occ[MTX] == 2'h0)
		else $error("master tx not empty after drain");
	AST_STX_DRAIN: assert property (seq_fsta_write ##0 dat_i[8] |=> occ[STX] == 2'h0)
		else $error("slave tx not empty after drain");
	AST_DRAIN_ZERO_NOP: assert property (seq_fsta_write ##0 !dat_i[9] && !dat_i[8]
		|-> drain == '0)
		else $error("zero write triggered a drain");
	AST_DRAIN_NO_STATE: assert property (!wr_take |-> drain == '0)
		else $error("drain active without a write");
	AST_MRX_FIELD: assert property (seq_fsta_read |=> ack_o && dat_o[7:6] == $past(occ[MRX]))
		else $error("master rx occupancy misreported");
	AST_MTX_FIELD: assert property (seq_fsta_read |=> ack_o && dat_o[5:4] == $past(occ[MTX]))
		else $error("master tx occupancy misreported");
	AST_SRX_FIELD: assert property (seq_fsta_read |=> ack_o && dat_o[3:2] == $past(occ[SRX]))
		else $error("slave rx occupancy misreported");
	AST_STX_FIELD: assert property (seq_fsta_read |=> ack_o && dat_o[1:0] == $past(occ[STX]))
		else $error("slave tx occupancy misreported");
	AST_NO_CODE3: assert property (occ[MRX] != 2'h3 && occ[MTX] != 2'h3
		&& occ[SRX] != 2'h3 && occ[STX] != 2'h3)
		else $error("reserved occupancy code seen");
	AST_SHARED_RESET: assert property (seq_shcon_reset |=> !bus_occupied_flag_o
		&& !start_detect_o && !stop_detect_o)
		else $error("detectors not reset by shared reset");
	AST_OCCUPIED_CLEAR: assert property (seq_shcon_reset |=> !bus_occupied_flag_o ##1
		(!bus_occupied_flag_o || start_detect_o))
		else $error("bus occupied flag not cleared");
	AST_DRAIN_EMPTY_NEXT: assert property (seq_fsta_write ##0 dat_i[9] |=> !pop_o[MTX].valid
		&& push_ready_o[MTX])
		else $error("master tx not restarted after drain");
	AST_ACK_ONE_WAIT: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
		else $error("wishbone ack timing wrong");
	AST_TIMEOUT_STICKY: assert property (master_stretch_timeout_i |=> mst_timeout)
		else $error("master timeout event lost");
endmodule // ifs_top
`default_nettype wire

// *** inc/ifs_pkg.sv ***
// package for the fifo occupancy, drain and detector-reset block
// assumes a 32-bit classic wishbone bus with byte addresses
`default_nettype none
package ifs_pkg;
	// register byte addresses
	localparam logic [31:0] IFS_ADDR_FIFO_STATUS   = 32'h4000_304c;
	localparam logic [31:0] IFS_ADDR_SHARED_CTRL   = 32'h4000_3050;
	localparam logic [31:0] IFS_ADDR_STRETCH_CTRL  = 32'h4000_3058;
	// reset values
	localparam logic [15:0] IFS_RST_FIFO_STATUS    = 16'h0000;
	localparam logic [15:0] IFS_RST_SHARED_CTRL    = 16'h0000;
	localparam logic [15:0] IFS_RST_STRETCH_CTRL   = 16'h0000;
	localparam logic [31:0] IFS_RST_WB_DATA        = 32'h0000_0000;
	// fifo status field positions
	localparam int          IFS_BIT_MTX_DRAIN      = 9;
	localparam int          IFS_BIT_STX_DRAIN      = 8;
	localparam int          IFS_BIT_MRX_OCC_LO     = 6;
	localparam int          IFS_BIT_MTX_OCC_LO     = 4;
	localparam int          IFS_BIT_SRX_OCC_LO     = 2;
	localparam int          IFS_BIT_STX_OCC_LO     = 0;
	// shared control field position
	localparam int          IFS_BIT_DET_RESET      = 0;
	// stretch control field positions
	localparam int          IFS_BIT_SLV_TIMEOUT    = 9;
	localparam int          IFS_BIT_MST_TIMEOUT    = 8;
	localparam int          IFS_BIT_SLV_STRETCH_LO = 4;
	localparam int          IFS_BIT_MST_STRETCH_LO = 0;
	// fifo indices, each index i owns occupancy bits [2i+1:2i]
	localparam int          IFS_FIFO_STX           = 0;
	localparam int          IFS_FIFO_SRX           = 1;
	localparam int          IFS_FIFO_MTX           = 2;
	localparam int          IFS_FIFO_MRX           = 3;
	localparam int          IFS_FIFO_COUNT         = 4;
	localparam int          IFS_FIFO_DEPTH         = 2;
	localparam int          IFS_BYTE_W             = 8;
	// occupancy codes
	localparam logic [1:0]  IFS_OCC_EMPTY          = 2'h0;
	localparam logic [1:0]  IFS_OCC_ONE            = 2'h1;
	localparam logic [1:0]  IFS_OCC_TWO            = 2'h2;
	// idle level of both bus lines after reset
	localparam logic        IFS_LINE_IDLE          = 1'b1;

	typedef struct packed {
		logic                  valid;
		logic [IFS_BYTE_W-1:0] data;
	} ifs_stream_type;
endpackage
`default_nettype wire

// *** test/ifs_bus_partner.sv ***
// remote bus device model: drives scl and sda as a far master would
// assumes open-drain lines with pull-ups, so released lines sit high
`default_nettype none
module ifs_bus_partner (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// command: 1 start and clock, 2 stop
	input  wire logic [1:0] cmd_i,
	// bus lines
	output logic            scl_o,
	output logic            sda_o,
	// frame in progress
	output logic            busy_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [4:0] step;
	// scl half period is 4 clocks, so the link clock runs at 200 ns
	// scl stands high between frames; sda only moves while scl is high for start and stop
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scl_o  <= 1'b1;
			sda_o  <= 1'b1;
			busy_o <= 1'b0;
			step   <= 5'h00;
		end else if (cmd_i == 2'h1) begin
			sda_o  <= 1'b0;
			busy_o <= 1'b1;
			step   <= 5'h00;
		end else if (cmd_i == 2'h2) begin
			sda_o <= 1'b1;
		end else if (busy_o) begin
			step <= step + 5'h01;
			if (step[1:0] == 2'h3) begin
				scl_o <= ~scl_o;
			end
			if (step == 5'h0f) begin
				busy_o <= 1'b0;
			end
		end
	end
endmodule // ifs_bus_partner
`default_nettype wire

// *** test/tb.sv ***
// self-checking bench for the fifo occupancy, drain and detector-reset block
// assumes ifs_top and the bus partner model are compiled before it
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic                          clk_i      = 1'b0;
	logic                          rst_i      = 1'b1;
	logic [31:0]                   adr        = 32'h0000_0000;
	logic [31:0]                   wdat       = 32'h0000_0000;
	logic [3:0]                    sel        = 4'h0;
	logic                          we         = 1'b0;
	logic                          cyc        = 1'b0;
	logic                          stb        = 1'b0;
	ifs_pkg::ifs_stream_type [3:0] push       = '0;
	logic [3:0]                    pop_ready  = 4'h0;
	logic                          mto        = 1'b0;
	logic                          sto        = 1'b0;
	logic [1:0]                    cmd        = 2'h0;
	logic [31:0]                   rdat;
	logic                          ack;
	logic                          scl;
	logic                          sda;
	logic                          occ_flag;
	logic                          start_det;
	logic                          stop_det;
	logic [3:0]                    push_ready;
	ifs_pkg::ifs_stream_type [3:0] pop;
	logic [3:0]                    mmode;
	logic [3:0]                    smode;
	logic                          lbusy;
	logic [31:0]                   q;
	logic [1:0]                    cnt [4];
	int                            fails      = 0;
	int                            compares   = 0;
	int                            starts     = 0;
	int                            stops      = 0;

	always #12.5 clk_i = ~clk_i;

	ifs_top DUT (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat), .sel_i(sel),
		.we_i(we), .cyc_i(cyc), .stb_i(stb), .dat_o(rdat), .ack_o(ack), .scl_i(scl),
		.sda_i(sda), .bus_occupied_flag_o(occ_flag), .start_detect_o(start_det),
		.stop_detect_o(stop_det), .push_i(push), .push_ready_o(push_ready), .pop_o(pop),
		.pop_ready_i(pop_ready), .master_stretch_mode_o(mmode), .slave_stretch_mode_o(smode),
		.master_stretch_timeout_i(mto), .slave_stretch_timeout_i(sto));

	ifs_bus_partner partner (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd), .scl_o(scl),
		.sda_o(sda), .busy_o(lbusy));

	always @(posedge clk_i) begin
		if (start_det === 1'b1) starts++;
		if (stop_det === 1'b1) stops++;
	end

	task automatic wrap_up();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one classic cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		sel  <= 4'h3;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) fails++;
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask

	// expected status word from the model's counts, fifo i in bits 2i+1:2i
	task automatic status(input string name);
		wb(1'b0, ifs_pkg::IFS_ADDR_FIFO_STATUS, 32'h0000_0000);
		check(name, q, {24'h00_0000, cnt[3], cnt[2], cnt[1], cnt[0]});
	endtask

	task automatic push_byte(input int i, input logic [7:0] d);
		@(posedge clk_i);
		push[i] <= {1'b1, d};
		@(posedge clk_i);
		push[i] <= '0;
		if (cnt[i] < 2'h2) cnt[i]++;
	endtask

	task automatic pop_byte(input int i, input logic [7:0] d);
		@(posedge clk_i);
		check("pop_valid", {31'h0, pop[i].valid}, 32'h0000_0001);
		check("pop_data", {24'h0, pop[i].data}, {24'h0, d});
		pop_ready[i] <= 1'b1;
		@(posedge clk_i);
		pop_ready[i] <= 1'b0;
		cnt[i]--;
	endtask

	// lets the detector's three-edge latency pass once the frame has settled
	task automatic partner_cmd(input logic [1:0] c);
		int n;
		n = 0;
		@(posedge clk_i);
		cmd <= c;
		@(posedge clk_i);
		cmd <= 2'h0;
		repeat (2) @(posedge clk_i);
		while (lbusy === 1'b1 && n < 100) begin
			@(posedge clk_i);
			n++;
		end
		repeat (8) @(posedge clk_i);
	endtask

	task automatic t_reset();
		status("fifo_status_reset");
		wb(1'b0, ifs_pkg::IFS_ADDR_SHARED_CTRL, 32'h0000_0000);
		check("shared_ctrl_reset", q, 32'h0000_0000);
		wb(1'b0, ifs_pkg::IFS_ADDR_STRETCH_CTRL, 32'h0000_0000);
		check("stretch_reset", q, 32'h0000_0000);
		wb(1'b1, 32'h4000_3054, 32'h0000_ffff);
		wb(1'b0, 32'h4000_3054, 32'h0000_0000);
		check("unmapped", q, 32'h0000_0000);
		check("push_ready_reset", {28'h0, push_ready}, 32'h0000_000f);
		check("flag_reset", {31'h0, occ_flag}, 32'h0000_0000);
	endtask

	// every fifo is filled until it refuses, then drained in arrival order
	task automatic t_fill();
		for (int i = 0; i < 4; i++) begin
			push_byte(i, 8'h10 + 8'(i));
			status("occ_one");
			push_byte(i, 8'h20 + 8'(i));
			status("occ_two");
			check("push_ready_full", {31'h0, push_ready[i]}, 32'h0000_0000);
			push_byte(i, 8'h30);
			status("occ_never_three");
			pop_byte(i, 8'h10 + 8'(i));
			pop_byte(i, 8'h20 + 8'(i));
			status("occ_empty");
		end
	endtask

	task automatic t_drain();
		push_byte(ifs_pkg::IFS_FIFO_MTX, 8'h01);
		push_byte(ifs_pkg::IFS_FIFO_MTX, 8'h02);
		push_byte(ifs_pkg::IFS_FIFO_STX, 8'h03);
		push_byte(ifs_pkg::IFS_FIFO_STX, 8'h04);
		push_byte(ifs_pkg::IFS_FIFO_MRX, 8'h05);
		wb(1'b1, ifs_pkg::IFS_ADDR_FIFO_STATUS, 32'h0000_0000);
		status("drain_zero");
		// software drains master tx with bit 9 first, then slave tx with bit 8
		wb(1'b1, ifs_pkg::IFS_ADDR_FIFO_STATUS, 32'h0000_0200);
		cnt[ifs_pkg::IFS_FIFO_MTX] = 2'h0;
		status("drain_master");
		check("mtx_pop_gone", {31'h0, pop[2].valid}, 32'h0000_0000);
		wb(1'b1, ifs_pkg::IFS_ADDR_FIFO_STATUS, 32'h0000_0100);
		cnt[ifs_pkg::IFS_FIFO_STX] = 2'h0;
		status("drain_slave");
		wb(1'b1, ifs_pkg::IFS_ADDR_FIFO_STATUS, 32'h0000_0000);
		status("drain_no_state");
		push_byte(ifs_pkg::IFS_FIFO_MTX, 8'h5a);
		status("after_drain_one");
		pop_byte(ifs_pkg::IFS_FIFO_MTX, 8'h5a);
		pop_byte(ifs_pkg::IFS_FIFO_MRX, 8'h05);
		status("drain_done");
	endtask

	task automatic t_detect();
		partner_cmd(2'h1);
		check("flag_on_start", {31'h0, occ_flag}, 32'h0000_0001);
		check("start_count", 32'(starts), 32'h0000_0001);
		wb(1'b1, ifs_pkg::IFS_ADDR_SHARED_CTRL, 32'h0000_0001);
		repeat (2) @(posedge clk_i);
		check("flag_cleared", {31'h0, occ_flag}, 32'h0000_0000);
		check("no_false_start", 32'(starts), 32'h0000_0001);
		partner_cmd(2'h2);
		check("flag_after_stop", {31'h0, occ_flag}, 32'h0000_0000);
		partner_cmd(2'h1);
		check("flag_restart", {31'h0, occ_flag}, 32'h0000_0001);
		check("start_again", 32'(starts), 32'h0000_0002);
		partner_cmd(2'h2);
		check("flag_stop", {31'h0, occ_flag}, 32'h0000_0000);
		check("stop_count", 32'(stops), 32'h0000_0002);
	endtask

	task automatic t_stretch();
		wb(1'b1, ifs_pkg::IFS_ADDR_STRETCH_CTRL, 32'h0000_00a5);
		// the write lands at the ack edge, so the modes show one edge later
		@(posedge clk_i);
		check("modes", {24'h0, smode, mmode}, 32'h0000_00a5);
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_i);
			mto <= (i == 0);
			sto <= (i == 1);
			@(posedge clk_i);
			mto <= 1'b0;
			sto <= 1'b0;
			wb(1'b0, ifs_pkg::IFS_ADDR_STRETCH_CTRL, 32'h0000_0000);
			check("timeout_set", q, 32'h0000_00a5 | (32'h0000_0100 << i));
			wb(1'b0, ifs_pkg::IFS_ADDR_STRETCH_CTRL, 32'h0000_0000);
			check("timeout_clear", q, 32'h0000_00a5);
		end
	endtask

	initial begin
		for (int i = 0; i < 4; i++) cnt[i] = 2'h0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_fill();
		t_drain();
		t_detect();
		t_stretch();
		wrap_up();
	end

	// the whole run needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		wrap_up();
	end
endmodule // tb
`default_nettype wire
